// *** logic/qr_fixed_pwm_gate_sequencer.sv ***
// top: fixed-frequency and quasi-resonant gate sequencer, axi4-lite regs
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module qr_fixed_pwm_gate_sequencer (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  // axi4-lite write channels
  input  wire logic [pwm_seq_pkg::AW-1:0]  i_awaddr,
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  output logic [1:0]                       o_bresp,
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  // axi4-lite read channels
  input  wire logic [pwm_seq_pkg::AW-1:0]  i_araddr,
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  output logic [31:0]                      o_rdata,
  output logic [1:0]                       o_rresp,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  // analog comparators
  input  wire logic                        i_peak_trip,
  input  wire logic                        i_sat_detect,
  // gate drives and timer clear
  output logic                             o_primary_gate_drive,
  output logic                             o_secondary_gate_drive,
  output logic                             o_cycle_timer_clear
);
  import pwm_seq_pkg::*;

  logic          aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [AW-1:0] aw_addr_q, aw_addr_d;
  logic [31:0]   w_data_q, w_data_d, rdata_q, rdata_d, rd_word;
  logic [3:0]    w_strb_q, w_strb_d;
  logic          bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]    bresp_q, bresp_d, rresp_q, rresp_d;
  logic          do_wr, wr_ok, rd_ok;
  logic [7:0]    ctrl_q, ctrl_d, per_q, per_d, duty_q, duty_d;
  logic [7:0]    dead_q, dead_d, blank_q, blank_d, satc_q, satc_d;
  logic [4:0]    acc_q, acc_d;
  logic [5:0]    acc_sum;
  logic [7:0]    tmr_q, tmr_d, ton_q, ton_d, period_eff;
  phase_t        st_q, st_d;
  logic          off_q, off_d, cyc_ff_q, cyc_ff_d, sat_prev_q;
  logic          pri_q, pri_d, sec_q, sec_d;
  logic          tick, run, quasi_resonant_mode, timer_watchdog_enable;
  logic          tmr_evt, timer_clear, sat_fall, set_fire;
  logic          cycle_start, trip_ok, duty_hit, pri_off;

  shot_if rst_sh ();
  shot_if set_sh ();
  shot_if dead_sh ();
  shot_if blank_sh ();

  // ---- axi4-lite slave ----
  assign o_awready = !aw_have_q && !bvalid_q;
  assign o_wready  = !w_have_q && !bvalid_q;
  assign o_arready = !rvalid_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_rvalid  = rvalid_q;
  assign o_rresp   = rresp_q;
  assign o_rdata   = rdata_q;
  assign do_wr     = aw_have_q && w_have_q;

  always_comb begin
    wr_ok = 1'b1;
    unique case (aw_addr_q)
      ADDR_CTRL, ADDR_PER, ADDR_DUTY, ADDR_DEAD,
      ADDR_BLANK, ADDR_SATC, ADDR_STAT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (i_araddr)
      ADDR_CTRL:  rd_word[7:0] = ctrl_q;
      ADDR_PER:   rd_word[7:0] = per_q;
      ADDR_DUTY:  rd_word[7:0] = duty_q;
      ADDR_DEAD:  rd_word[7:0] = dead_q;
      ADDR_BLANK: rd_word[7:0] = blank_q;
      ADDR_SATC:  rd_word[7:0] = satc_q;
      ADDR_STAT:  rd_word[15:0] = {tmr_q, 3'h0, rst_sh.busy,
                                   cyc_ff_q, off_q, sec_q, pri_q};
      default:    rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (i_awvalid && o_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_have_d = 1'b1;
      w_data_d = i_wdata;
      w_strb_d = i_wstrb;
    end
    if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_ok ? rd_word : 32'h0000_0000;
      rresp_d  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // ---- register file; every writable field lives in byte lane 0 ----
  always_comb begin
    ctrl_d  = ctrl_q;
    per_d   = per_q;
    duty_d  = duty_q;
    dead_d  = dead_q;
    blank_d = blank_q;
    satc_d  = satc_q;
    if (do_wr && w_strb_q[0]) begin
      unique case (aw_addr_q)
        ADDR_CTRL:  ctrl_d  = w_data_q[7:0] & CTRL_MASK;
        ADDR_PER:   per_d   = w_data_q[7:0];
        ADDR_DUTY:  duty_d  = w_data_q[7:0];
        ADDR_DEAD:  dead_d  = w_data_q[7:0] & DEAD_MASK;
        ADDR_BLANK: blank_d = w_data_q[7:0] & BLANK_MASK;
        ADDR_SATC:  satc_d  = w_data_q[7:0] & SATC_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctrl_q  <= CTRL_RST;
      per_q   <= PER_RST;
      duty_q  <= DUTY_RST;
      dead_q  <= DEAD_RST;
      blank_q <= BLANK_RST;
      satc_q  <= SATC_RST;
    end else begin
      ctrl_q  <= ctrl_d;
      per_q   <= per_d;
      duty_q  <= duty_d;
      dead_q  <= dead_d;
      blank_q <= blank_d;
      satc_q  <= satc_d;
    end
  end

  // ---- 8 mhz tick: fractional divider, exact on average ----
  assign acc_sum = {1'b0, acc_q} + {1'b0, TICK_INC};
  assign tick    = acc_sum >= {1'b0, TICK_MOD};
  always_comb begin
    acc_d = tick ? 5'(acc_sum - {1'b0, TICK_MOD}) : acc_sum[4:0];
  end

  // ---- cycle logic ----
  assign run                   = ctrl_q[CTRL_RUN];
  assign quasi_resonant_mode   = satc_q[SATC_ENABLE];
  assign timer_watchdog_enable = satc_q[SATC_WDE];
  // values below the floor would exceed 2 mhz, so they are clamped
  assign period_eff = (per_q < PERIOD_MIN) ? PERIOD_MIN : per_q;
  assign tmr_evt    = run && tick && (tmr_q >= period_eff);
  assign timer_clear = quasi_resonant_mode && rst_sh.busy;
  // noise right after the switch edge is masked by the clearing pulse
  assign sat_fall = quasi_resonant_mode && sat_prev_q
                    && !i_sat_detect && !rst_sh.busy;
  assign set_fire = sat_fall && !cyc_ff_q;
  assign cycle_start = run && (quasi_resonant_mode
                       ? (set_fire || (timer_watchdog_enable && tmr_evt))
                       : tmr_evt);
  assign trip_ok  = i_peak_trip && !blank_sh.busy;
  assign duty_hit = ton_q >= duty_q;
  assign pri_off  = (st_q == ST_PRI) && (trip_ok || duty_hit);

  assign rst_sh.len   = RST_SHOT_CYC;
  assign set_sh.len   = SET_SHOT_CYC;
  assign set_sh.fire  = set_fire;
  assign dead_sh.len  = ns_to_cyc((int'(dead_q[3:0]) + 1)
                                  * DEAD_STEP_NS);
  assign o_cycle_timer_clear = timer_clear;

  always_comb begin
    unique case (blank_q[1:0])
      2'h0: blank_sh.len = BLANK0_CYC;
      2'h1: blank_sh.len = BLANK1_CYC;
      2'h2: blank_sh.len = BLANK2_CYC;
      2'h3: blank_sh.len = BLANK3_CYC;
    endcase
  end

  always_comb begin
    st_d          = st_q;
    off_d         = off_q;
    cyc_ff_d      = cyc_ff_q;
    ton_d         = ton_q;
    tmr_d         = tmr_q;
    dead_sh.fire  = 1'b0;
    blank_sh.fire = 1'b0;
    rst_sh.fire   = 1'b0;
    if (cycle_start) begin
      off_d = 1'b0;
      ton_d = 8'h00;
    end else if (st_q == ST_PRI && tick && ton_q != 8'hFF) begin
      ton_d = ton_q + 8'h01;
    end
    if (pri_off) begin
      off_d = 1'b1; // set beats clear
    end
    if (rst_sh.busy) begin
      cyc_ff_d = 1'b0;
    end
    if (sat_fall) begin
      cyc_ff_d = 1'b1;
    end
    if (!run || timer_clear) begin
      tmr_d = 8'h00;
    end else if (tick) begin
      tmr_d = tmr_evt ? 8'h00 : tmr_q + 8'h01;
    end
    unique case (st_q)
      ST_IDLE, ST_SEC: begin
        if (cycle_start) begin
          st_d         = ST_DEAD_SP;
          dead_sh.fire = 1'b1;
        end
      end
      ST_PRI: begin
        if (pri_off) begin
          st_d         = ST_DEAD_PS;
          dead_sh.fire = 1'b1;
          rst_sh.fire  = quasi_resonant_mode;
        end
      end
      ST_DEAD_PS: begin
        if (!dead_sh.busy) begin
          st_d = ST_SEC;
        end
      end
      ST_DEAD_SP: begin
        if (!dead_sh.busy) begin
          st_d          = ST_PRI;
          blank_sh.fire = 1'b1;
        end
      end
    endcase
    if (!run) begin
      st_d = ST_IDLE;
    end
    pri_d = run && ctrl_q[CTRL_PRI_EN] && st_d == ST_PRI && !off_d;
    sec_d = run && ctrl_q[CTRL_SEC_EN] && st_d == ST_SEC;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      acc_q      <= 5'h00;
      tmr_q      <= 8'h00;
      ton_q      <= 8'h00;
      st_q       <= ST_IDLE;
      off_q      <= 1'b0;
      cyc_ff_q   <= 1'b0;
      sat_prev_q <= 1'b0;
      pri_q      <= 1'b0;
      sec_q      <= 1'b0;
    end else begin
      acc_q      <= acc_d;
      tmr_q      <= tmr_d;
      ton_q      <= ton_d;
      st_q       <= st_d;
      off_q      <= off_d;
      cyc_ff_q   <= cyc_ff_d;
      sat_prev_q <= i_sat_detect;
      pri_q      <= pri_d;
      sec_q      <= sec_d;
    end
  end

  assign o_primary_gate_drive   = pri_q;
  assign o_secondary_gate_drive = sec_q;

  pulse_timer u_rst_shot   (.i_clk(i_clk), .i_nrst(i_nrst), .u_if(rst_sh));
  pulse_timer u_set_shot   (.i_clk(i_clk), .i_nrst(i_nrst), .u_if(set_sh));
  pulse_timer u_dead_timer (.i_clk(i_clk), .i_nrst(i_nrst), .u_if(dead_sh));
  pulse_timer u_blank_tmr  (.i_clk(i_clk), .i_nrst(i_nrst), .u_if(blank_sh));

  // ---- checks ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_no_overlap: assert property (!(pri_q && sec_q))
    else $error("gate drives overlap");
  a_dead_gap: assert property (pri_q ##1 !pri_q |-> !sec_q ##1 !sec_q)
    else $error("secondary rose without dead time");
  a_pri_disable: assert property (!ctrl_q[CTRL_PRI_EN] |=> !pri_q)
    else $error("disabled primary drive high");
  a_sec_disable: assert property (!ctrl_q[CTRL_SEC_EN] |=> !sec_q)
    else $error("disabled secondary drive high");
  a_trip_latch: assert property (st_q == ST_PRI && trip_ok |=> !pri_q)
    else $error("primary not cut on peak trip");
  a_latch_hold: assert property (off_q && !cycle_start |=> off_q)
    else $error("off latch released early");
  a_duty_cap: assert property (st_q == ST_PRI && duty_hit |=> !pri_q)
    else $error("primary exceeded duty limit");
  a_blank_mask: assert property (blank_sh.busy |-> !trip_ok)
    else $error("peak trip seen during blanking");
  a_qr_clear: assert property (quasi_resonant_mode && pri_off
    |=> rst_sh.busy [*8])
    else $error("clearing pulse missing");
  a_timer_clear: assert property (timer_clear |=> tmr_q == 8'h00)
    else $error("period timer not cleared");
  a_noise_mask: assert property (rst_sh.busy |-> !set_fire)
    else $error("saturation edge not masked");
  a_sat_start: assert property (set_fire && run && st_q == ST_SEC
    |=> st_q == ST_DEAD_SP && !sec_q)
    else $error("saturation fall did not end secondary");
  a_fixed_period: assert property (run && tick && tmr_q == period_eff
    && !timer_clear |=> tmr_q == 8'h00)
    else $error("period timer did not wrap at n");
  a_fixed_start: assert property (!quasi_resonant_mode && tmr_evt
    && st_q == ST_SEC |=> st_q == ST_DEAD_SP)
    else $error("fixed cycle not started");
  a_watchdog: assert property (run && quasi_resonant_mode
    && timer_watchdog_enable && tmr_evt && st_q == ST_SEC
    |=> st_q == ST_DEAD_SP)
    else $error("watchdog did not restart");
  a_sat_off: assert property (!quasi_resonant_mode
    |-> !set_fire && !timer_clear)
    else $error("saturation path active while disabled");
  a_reset_state: assert property (disable iff (1'b0) !i_nrst
    |=> !pri_q && !sec_q && !cyc_ff_q && !rst_sh.busy)
    else $error("reset state wrong");

  c_qr_cycle: cover property (set_fire && st_q == ST_SEC);
  c_fixed_cycle: cover property (!quasi_resonant_mode && tmr_evt
    && st_q == ST_SEC);
  c_peak_trip: cover property (st_q == ST_PRI && trip_ok);
endmodule

// *** logic/pwm_seq_pkg.sv ***
// package: constants, register map and states of the gate sequencer
// Contract
// - fixed frequency is 8 MHz over N, 4..256
// - timer event starts cycle on one tick
// - duty limit register caps primary on-time
// - peak trip latches primary off until next cycle
// - secondary rises only after dead time
// - primary-off fires 200 ns clearing one-shot
// - saturation edges ignored during clearing pulse
// - saturation fall sets flop, 33 ns shot
// - no clearing pulse lets timer run on
// - watchdog enable lets timer restart switching
// - saturation detect selectable on or off
// - each gate drive has own enable
// - blank peak comparison after primary turn-on
// - dead time in its own register
package pwm_seq_pkg;
  localparam int AW            = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_MHZ       = 100;
  localparam int TICK_MHZ      = 8;
  localparam int TICK_GCD      = 4;
  localparam logic [4:0] TICK_INC = 5'(TICK_MHZ / TICK_GCD);
  localparam logic [4:0] TICK_MOD = 5'(CLK_MHZ / TICK_GCD);

  // least time rounds up so no pulse falls short
  function automatic logic [7:0] ns_to_cyc(input int ns);
    return 8'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  localparam int RST_SHOT_NS  = 200;
  localparam int SET_SHOT_NS  = 33;
  localparam int DEAD_STEP_NS = 16;
  localparam int BLANK0_NS    = 0;
  localparam int BLANK1_NS    = 50;
  localparam int BLANK2_NS    = 100;
  localparam int BLANK3_NS    = 200;
  localparam logic [7:0] RST_SHOT_CYC = ns_to_cyc(RST_SHOT_NS);
  localparam logic [7:0] SET_SHOT_CYC = ns_to_cyc(SET_SHOT_NS);
  localparam logic [7:0] BLANK0_CYC   = ns_to_cyc(BLANK0_NS);
  localparam logic [7:0] BLANK1_CYC   = ns_to_cyc(BLANK1_NS);
  localparam logic [7:0] BLANK2_CYC   = ns_to_cyc(BLANK2_NS);
  localparam logic [7:0] BLANK3_CYC   = ns_to_cyc(BLANK3_NS);

  // register byte offsets
  localparam logic [AW-1:0] ADDR_CTRL  = 8'h00;
  localparam logic [AW-1:0] ADDR_PER   = 8'h04;
  localparam logic [AW-1:0] ADDR_DUTY  = 8'h08;
  localparam logic [AW-1:0] ADDR_DEAD  = 8'h0C;
  localparam logic [AW-1:0] ADDR_BLANK = 8'h10;
  localparam logic [AW-1:0] ADDR_SATC  = 8'h14;
  localparam logic [AW-1:0] ADDR_STAT  = 8'h18;

  // writable field masks and reset values
  localparam logic [7:0] CTRL_MASK  = 8'h07;
  localparam logic [7:0] DEAD_MASK  = 8'h0F;
  localparam logic [7:0] BLANK_MASK = 8'h03;
  localparam logic [7:0] SATC_MASK  = 8'h03;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] PER_RST    = 8'h3F;
  localparam logic [7:0] DUTY_RST   = 8'h20;
  localparam logic [7:0] DEAD_RST   = 8'h00;
  localparam logic [7:0] BLANK_RST  = 8'h00;
  localparam logic [7:0] SATC_RST   = 8'h00;
  localparam logic [7:0] PERIOD_MIN = 8'h03;

  // field positions
  localparam int CTRL_PRI_EN = 0;
  localparam int CTRL_SEC_EN = 1;
  localparam int CTRL_RUN    = 2;
  localparam int SATC_ENABLE = 0;
  localparam int SATC_WDE    = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRI, ST_DEAD_PS, ST_SEC, ST_DEAD_SP
  } phase_t;
endpackage

// *** logic/shot_if.sv ***
// interface: trigger, length and busy between sequencer and pulse timers
`timescale 1ns/1ps
interface shot_if;
  logic       fire;
  logic [7:0] len;
  logic       busy;
  modport ctrl  (output fire, output len, input busy);
  modport timer (input fire, input len, output busy);
endinterface

// *** logic/pulse_timer.sv ***
// one-shot: busy for exactly len cycles after fire
`timescale 1ns/1ps
module pulse_timer (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // trigger side
  shot_if.timer     u_if
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // a new fire restarts the pulse rather than extending it
  always_comb begin
    cnt_d = cnt_q;
    if (u_if.fire) begin
      cnt_d = u_if.len;
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign u_if.busy = (cnt_q != 8'h00);

  a_shot_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
    u_if.fire |=> cnt_q == $past(u_if.len))
    else $error("pulse length not loaded");
  a_shot_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (u_if.busy && !u_if.fire) |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("pulse count not decrementing");
endmodule

// *** tb/comp_model.sv ***
// partner model: peak-current and saturation comparators
`timescale 1ns/1ps
module comp_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // gate drives and comparator timing
  input  wire logic i_pri,
  input  wire logic i_sec,
  input  int        i_trip_dly,
  input  int        i_sat_dly,
  // comparator outputs
  output logic      o_trip,
  output logic      o_sat
);
  int on_q;
  int sec_q;
  // current ramps while primary conducts; zero delay means no trip
  always @(posedge i_clk) begin
    on_q   <= (i_nrst && i_pri) ? on_q + 1 : 0;
    sec_q  <= (i_nrst && i_sec) ? sec_q + 1 : 0;
    o_trip <= i_nrst && i_pri && i_trip_dly != 0 && on_q + 1 >= i_trip_dly;
    // winding runs dry after the set delay, recharges on primary
    if (!i_nrst || i_pri) begin
      o_sat <= 1'h1;
    end else if (i_sec && sec_q + 1 >= i_sat_dly) begin
      o_sat <= 1'h0;
    end
  end
endmodule

// *** tb/tb.sv ***
// testbench: register map, fixed and resonant gate sequencing
`timescale 1ns/1ps
module tb;
  import pwm_seq_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
  logic        i_clk = 1'h0;
  logic        i_nrst = 1'h0;
  logic [7:0]  i_awaddr = 8'h00;
  logic [7:0]  i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_awvalid = 1'h0;
  logic        i_wvalid = 1'h0;
  logic        i_bready = 1'h0;
  logic        i_arvalid = 1'h0;
  logic        i_rready = 1'h0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp, resp;
  logic [31:0] o_rdata, rd;
  logic        trip, sat, pri, sec, clr, pri_p, sec_p, clr_p;
  int trip_dly = 0, sat_dly = 1000000, mismatches = 0, cmp_count = 0;
  int cyc = 0, rises = 0, t_rise = 0, t_fall = 0, t_srise = 0, per = 0;
  int on_len = 0, gap = 0, sec_len = 0, clr_cnt = 0, clr_len = 0;
  int overlap = 0, sec_hi = 0, d, lo, n, r0, s0;
  int bc [4] = '{0, 5, 10, 20};
  logic [7:0] fv [3] = '{8'h00, 8'h07, 8'h0F};
  logic [7:0] pv [4] = '{8'h00, 8'h07, 8'h0F, 8'hFF};
  row_t rows [7] = '{'{ADDR_CTRL, 32'h0, RESP_OKAY},
    '{ADDR_PER, {24'h0, PER_RST}, RESP_OKAY},
    '{ADDR_DUTY, {24'h0, DUTY_RST}, RESP_OKAY},
    '{ADDR_DEAD, 32'h0, RESP_OKAY}, '{ADDR_BLANK, 32'h0, RESP_OKAY},
    '{ADDR_SATC, 32'h0, RESP_OKAY}, '{8'h1C, 32'h0, RESP_SLVERR}};

  always #5 i_clk = ~i_clk;

  qr_fixed_pwm_gate_sequencer u_qr_fixed_pwm_gate_sequencer (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
    .i_wstrb(4'hF), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .i_peak_trip(trip), .i_sat_detect(sat),
    .o_primary_gate_drive(pri), .o_secondary_gate_drive(sec),
    .o_cycle_timer_clear(clr));

  comp_model u_comp_model (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_pri(pri), .i_sec(sec),
    .i_trip_dly(trip_dly), .i_sat_dly(sat_dly), .o_trip(trip),
    .o_sat(sat));

  // edge monitor on the falling edge, where registered outputs are settled
  always @(negedge i_clk) begin
    cyc++;
    if (pri === 1'h1 && pri_p === 1'h0) begin
      rises++;
      per = cyc - t_rise;
      t_rise = cyc;
    end
    if (pri === 1'h0 && pri_p === 1'h1) begin
      on_len = cyc - t_rise;
      t_fall = cyc;
    end
    if (sec === 1'h1 && sec_p === 1'h0) begin
      gap = cyc - t_fall;
      t_srise = cyc;
    end
    if (sec === 1'h0 && sec_p === 1'h1) sec_len = cyc - t_srise;
    if (clr === 1'h1) clr_cnt++;
    else if (clr_p === 1'h1) clr_len = clr_cnt;
    if (clr !== 1'h1) clr_cnt = 0;
    if (pri === 1'h1 && sec === 1'h1) overlap++;
    if (sec === 1'h1) sec_hi++;
    pri_p = pri;
    sec_p = sec;
    clr_p = clr;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cyc_wait(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok, b_ok;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    // ready and bvalid are read mid-cycle, so they describe the next edge
    do begin
      @(negedge i_clk);
      aw_ok = o_awready === 1'h1;
      w_ok = o_wready === 1'h1;
      b_ok = o_bvalid === 1'h1;
      resp = o_bresp;
      @(posedge i_clk);
      if (aw_ok) i_awvalid <= 1'h0;
      if (w_ok) i_wvalid <= 1'h0;
    end while (!b_ok);
    i_bready <= 1'h0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic ar_ok, r_ok;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      @(negedge i_clk);
      ar_ok = o_arready === 1'h1;
      r_ok = o_rvalid === 1'h1;
      rd = o_rdata;
      resp = o_rresp;
      @(posedge i_clk);
      if (ar_ok) i_arvalid <= 1'h0;
    end while (!r_ok);
    i_rready <= 1'h0;
  endtask

  task automatic complete_run;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // bound on the whole run, about two and a half times the expected length
  initial begin
    cyc_wait(90000);
    mismatches++;
    complete_run;
  end

  initial begin
    cyc_wait(20);
    i_nrst <= 1'h1;
    foreach (rows[i]) begin
      rd_reg(rows[i].a);
      chk(rd, rows[i].d);
      chk(32'(resp), 32'(rows[i].r));
    end
    wr(ADDR_STAT, 32'hFF);
    chk(32'(resp), 32'(RESP_OKAY));
    wr(ADDR_PER, 32'h0F);
    wr(ADDR_DUTY, 32'h08);
    wr(ADDR_CTRL, 32'h07);
    foreach (fv[i]) begin
      wr(ADDR_DEAD, {24'h0, fv[i]});
      cyc_wait(600);
      d = ((fv[i] + 1) * 16 + 9) / 10;
      chk(32'(gap >= d && gap <= d + 1), 32'h1);
    end
    trip_dly = 3;
    foreach (bc[i]) begin
      wr(ADDR_BLANK, 32'(i));
      cyc_wait(600);
      lo = bc[i] < 3 ? 3 : bc[i];
      chk(32'(on_len >= lo && on_len <= lo + 3), 32'h1);
      chk(per, 200);
    end
    trip_dly = 0;
    wr(ADDR_CTRL, 32'h05);
    cyc_wait(300);
    s0 = sec_hi;
    r0 = rises;
    cyc_wait(400);
    chk(sec_hi, s0);
    chk(32'(rises > r0), 32'h1);
    wr(ADDR_CTRL, 32'h06);
    cyc_wait(300);
    r0 = rises;
    cyc_wait(400);
    chk(rises, r0);
    wr(ADDR_CTRL, 32'h07);
    wr(ADDR_DEAD, 32'h0);
    // timer restarts on the next tick when the period shrinks, since it compares with >=
    foreach (pv[i]) begin
      n = (pv[i] < 3 ? 3 : pv[i]) + 1;
      wr(ADDR_PER, {24'h0, pv[i]});
      wr(ADDR_DUTY, 32'(n / 2));
      cyc_wait(3400 + n * 38);
      chk(per, n * 25 / 2);
      chk(32'(on_len <= n / 2 * 13 && on_len + 5 >= n / 2 * 12), 32'h1);
    end
    trip_dly = 5;
    sat_dly = 30;
    wr(ADDR_SATC, 32'h01);
    cyc_wait(600);
    chk(32'(sec_len >= 30 && sec_len <= 33), 32'h1);
    chk(clr_len, 20);
    chk(32'(per <= 60), 32'h1);
    sat_dly = 10;
    cyc_wait(300);
    chk(32'(sec), 32'h1);
    wr(ADDR_SATC, 32'h03);
    wr(ADDR_PER, 32'h3F);
    r0 = rises;
    cyc_wait(4500);
    chk(32'(rises > r0), 32'h1);
    @(posedge i_clk);
    i_nrst <= 1'h0;
    cyc_wait(3);
    chk(32'({pri, sec, clr}), 32'h0);
    i_nrst <= 1'h1;
    rd_reg(ADDR_CTRL);
    chk(rd, 32'h0);
    r0 = rises;
    cyc_wait(300);
    chk(rises, r0);
    chk(overlap, 0);
    complete_run;
  end
endmodule
